// *** include/acs_pkg.sv ***
// package: register map, field layout, modes and timing for the calibration sequencer
package acs_pkg;

  // register byte offsets
  localparam logic [7:0] ACS_CTRL_OFF = 8'h00;
  localparam logic [7:0] ACS_STAT_OFF = 8'h04;
  localparam logic [7:0] ACS_OFFCAL_OFF = 8'h08;
  localparam logic [7:0] ACS_FSCAL_OFF = 8'h0C;
  localparam logic [7:0] ACS_IRQ_STAT_OFF = 8'h10;
  localparam logic [7:0] ACS_IRQ_MASK_OFF = 8'h14;
  localparam logic [7:0] ACS_PERIOD_OFF = 8'h18;

  // control register fields
  localparam int ACS_MODE_LSB = 0;
  localparam int ACS_SLAVE_BIT = 4;

  // interrupt status bits
  localparam int ACS_IRQ_DONE = 0;
  localparam int ACS_IRQ_VALID = 1;
  localparam int ACS_IRQ_NUM = 2;

  // calibration lengths in conversion periods
  localparam logic [2:0] ACS_CAL_PERIODS = 3'h3;
  localparam logic [2:0] ACS_CAL_PERIODS_SLAVE = 3'h4;
  localparam logic [2:0] ACS_FILL_PERIODS = 3'h3;
  localparam logic [2:0] ACS_SYS_SETTLE_PERIODS = 3'h1;

  // default conversion period, in aclk cycles
  localparam logic [31:0] ACS_PERIOD_RST = 32'h0000_0100;
  localparam logic [23:0] ACS_CAL_RST = 24'h00_0000;
  localparam logic [1:0] ACS_RESP_OKAY = 2'h0;
  localparam logic [1:0] ACS_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ACS_MD_NORMAL = 3'b000,
    ACS_MD_SELF = 3'b001,
    ACS_MD_SYS_OFF = 3'b010,
    ACS_MD_SYS_FS = 3'b011,
    ACS_MD_PSEUDO = 3'b100,
    ACS_MD_BACKGND = 3'b101
  } acs_mode_e;

  typedef enum logic [1:0] {
    ACS_IN_ANALOG = 2'b00,
    ACS_IN_SHORTED = 2'b01,
    ACS_IN_REFERENCE = 2'b10
  } acs_input_e;

  // calibration engine hook-up: what the sequencer asks of the modulator
  typedef struct packed {
    acs_input_e input_sel;
    logic offset_cal;
    logic gain_cal;
  } acs_front_s;

  // calibration result from the modulator
  typedef struct packed {
    logic offset_done;
    logic gain_done;
    logic [23:0] result;
  } acs_result_s;

endpackage

// *** design/acs_period_timer.sv ***
// conversion period timer: one-cycle tick at each conversion-cycle boundary
`timescale 1ns/10ps
module acs_period_timer
  import acs_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] period,
  output logic tick
);

  logic [WIDTH-1:0] count_r;

  // a period of zero or one still ticks each cycle rather than stalling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
      tick <= 1'b0;
    end else if (ce) begin
      if (count_r + WIDTH'(1) >= period) begin
        count_r <= '0;
        tick <= 1'b1;
      end else begin
        count_r <= count_r + WIDTH'(1);
        tick <= 1'b0;
      end
    end
  end

endmodule

// *** design/acs_cal_sequencer.sv ***
// calibration sequencer for a delta-sigma converter with an AXI4-Lite register port
//
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module acs_cal_sequencer
  import acs_pkg::*;
#(
  parameter int PERIOD_W = 32
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire acs_result_s cal_result,
  output acs_front_s front,
  output logic result_valid_n,
  output logic conv_tick,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state

  typedef enum logic [2:0] {
    ACS_ST_NORMAL = 3'b000,
    ACS_ST_OFFSET = 3'b001,
    ACS_ST_GAIN = 3'b010,
    ACS_ST_FILL = 3'b011,
    ACS_ST_SETTLE = 3'b100
  } acs_state_e;

  acs_state_e state_r;
  logic [2:0] op_mode_field_r;
  logic slave_mode_r;
  logic first_bg_r;
  logic shorted_r;
  logic [2:0] phase_cnt_r;
  logic [PERIOD_W-1:0] period_r;
  logic [23:0] offset_cal_r;
  logic [23:0] fullscale_cal_r;
  logic [ACS_IRQ_NUM-1:0] irq_stat_r;
  logic [ACS_IRQ_NUM-1:0] irq_mask_r;
  logic tick;
  logic last_period;
  logic cal_done_ev;
  logic valid_ev;
  logic bg_gain_next_r;

  acs_period_timer #(
    .WIDTH(PERIOD_W)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .period(period_r),
    .tick(tick)
  );

  assign conv_tick = tick;
  assign last_period = (phase_cnt_r == 3'h1);

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: one write and one read at a time

  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic rd_go;
  logic wr_hit;
  logic rd_hit;
  logic sw_mode_wr;
  logic stat_rd;
  logic [31:0] rd_word;

  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold_r & ~s_axi_bvalid;
  assign wr_go = ce & aw_hold_r & w_hold_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go = ce & s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_r)
      ACS_CTRL_OFF, ACS_OFFCAL_OFF, ACS_FSCAL_OFF,
      ACS_IRQ_MASK_OFF, ACS_PERIOD_OFF, ACS_IRQ_STAT_OFF, ACS_STAT_OFF: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  assign sw_mode_wr = wr_go & (awaddr_r == ACS_CTRL_OFF) & wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ACS_RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ACS_CTRL_OFF: begin
        rd_word[ACS_MODE_LSB +: 3] = op_mode_field_r;
        rd_word[ACS_SLAVE_BIT] = slave_mode_r;
      end
      ACS_STAT_OFF: rd_word = {24'h00_0000, front, state_r, result_valid_n};
      ACS_OFFCAL_OFF: rd_word = {8'h00, offset_cal_r};
      ACS_FSCAL_OFF: rd_word = {8'h00, fullscale_cal_r};
      ACS_IRQ_STAT_OFF: rd_word[ACS_IRQ_NUM-1:0] = irq_stat_r;
      ACS_IRQ_MASK_OFF: rd_word[ACS_IRQ_NUM-1:0] = irq_mask_r;
      ACS_PERIOD_OFF: rd_word = 32'(period_r);
      default: rd_hit = 1'b0;
    endcase
  end

  assign stat_rd = rd_go & (s_axi_araddr == ACS_IRQ_STAT_OFF);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ACS_RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? ACS_RESP_OKAY : ACS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slave_mode_r <= 1'b0;
      period_r <= PERIOD_W'(ACS_PERIOD_RST);
      irq_mask_r <= '0;
    end else if (ce && wr_go) begin
      if (awaddr_r == ACS_CTRL_OFF && wstrb_r[0]) begin
        slave_mode_r <= wdata_r[ACS_SLAVE_BIT];
      end
      if (awaddr_r == ACS_PERIOD_OFF) begin
        period_r <= PERIOD_W'(wdata_r);
      end
      if (awaddr_r == ACS_IRQ_MASK_OFF && wstrb_r[0]) begin
        irq_mask_r <= wdata_r[ACS_IRQ_NUM-1:0];
      end
    end
  end

  // the calibration results; a host write replaces the correction in use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      offset_cal_r <= ACS_CAL_RST;
      fullscale_cal_r <= ACS_CAL_RST;
    end else if (ce) begin
      if (wr_go && awaddr_r == ACS_OFFCAL_OFF) begin
        offset_cal_r <= wdata_r[23:0];
      end else if (cal_result.offset_done) begin
        offset_cal_r <= cal_result.result;
      end
      if (wr_go && awaddr_r == ACS_FSCAL_OFF) begin
        fullscale_cal_r <= wdata_r[23:0];
      end else if (cal_result.gain_done) begin
        fullscale_cal_r <= cal_result.result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration sequence, advanced only at conversion-cycle boundaries

  function automatic logic [2:0] offset_len(input logic slave, input logic first);
    offset_len = (slave && first) ? ACS_CAL_PERIODS_SLAVE : ACS_CAL_PERIODS;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ACS_ST_NORMAL;
      op_mode_field_r <= ACS_MD_NORMAL;
      phase_cnt_r <= 3'h0;
      shorted_r <= 1'b0;
      first_bg_r <= 1'b1;
    end else if (ce) begin
      if (tick) begin
        unique case (state_r)
          ACS_ST_NORMAL: begin
            unique case (op_mode_field_r)
              ACS_MD_SELF, ACS_MD_BACKGND: begin
                state_r <= ACS_ST_OFFSET;
                shorted_r <= 1'b1;
                phase_cnt_r <= offset_len(slave_mode_r, 1'b1);
              end
              ACS_MD_SYS_OFF, ACS_MD_PSEUDO: begin
                state_r <= ACS_ST_OFFSET;
                shorted_r <= 1'b0;
                phase_cnt_r <= offset_len(slave_mode_r, 1'b1);
              end
              ACS_MD_SYS_FS: begin
                state_r <= ACS_ST_GAIN;
                phase_cnt_r <= offset_len(slave_mode_r, 1'b1);
              end
              default: state_r <= ACS_ST_NORMAL;
            endcase
          end
          ACS_ST_OFFSET: begin
            if (!last_period) begin
              phase_cnt_r <= phase_cnt_r - 3'h1;
            end else if (op_mode_field_r == ACS_MD_SYS_OFF) begin
              op_mode_field_r <= ACS_MD_NORMAL;
              state_r <= ACS_ST_SETTLE;
              phase_cnt_r <= ACS_SYS_SETTLE_PERIODS;
            end else if (op_mode_field_r == ACS_MD_BACKGND) begin
              // background runs offset, fill, gain, fill and loops
              shorted_r <= 1'b0;
              first_bg_r <= 1'b0;
              state_r <= ACS_ST_FILL;
              phase_cnt_r <= ACS_FILL_PERIODS;
            end else begin
              shorted_r <= 1'b0;
              state_r <= ACS_ST_GAIN;
              phase_cnt_r <= ACS_CAL_PERIODS;
            end
          end
          ACS_ST_GAIN: begin
            if (!last_period) begin
              phase_cnt_r <= phase_cnt_r - 3'h1;
            end else if (op_mode_field_r == ACS_MD_SYS_FS) begin
              op_mode_field_r <= ACS_MD_NORMAL;
              state_r <= ACS_ST_SETTLE;
              phase_cnt_r <= ACS_SYS_SETTLE_PERIODS;
            end else begin
              if (op_mode_field_r != ACS_MD_BACKGND) begin
                op_mode_field_r <= ACS_MD_NORMAL;
              end
              state_r <= ACS_ST_FILL;
              phase_cnt_r <= ACS_FILL_PERIODS;
            end
          end
          ACS_ST_FILL, ACS_ST_SETTLE: begin
            if (!last_period) begin
              phase_cnt_r <= phase_cnt_r - 3'h1;
            end else if (op_mode_field_r == ACS_MD_BACKGND) begin
              // this boundary is the valid cycle; the next cal starts with it
              if (state_r == ACS_ST_FILL && bg_gain_next_r) begin
                state_r <= ACS_ST_GAIN;
                phase_cnt_r <= ACS_CAL_PERIODS;
              end else begin
                state_r <= ACS_ST_OFFSET;
                shorted_r <= 1'b1;
                phase_cnt_r <= offset_len(slave_mode_r, first_bg_r);
              end
            end else begin
              state_r <= ACS_ST_NORMAL;
            end
          end
          default: state_r <= ACS_ST_NORMAL;
        endcase
      end
      // a host write lands at once and wins over the sequence's own clear;
      // the sequence only looks at it on a later tick
      if (sw_mode_wr) begin
        op_mode_field_r <= wdata_r[ACS_MODE_LSB +: 3];
        first_bg_r <= 1'b1;
      end
    end
  end

  // background alternates: after an offset fill a gain phase follows
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bg_gain_next_r <= 1'b0;
    end else if (ce && tick) begin
      if (state_r == ACS_ST_OFFSET && last_period) begin
        bg_gain_next_r <= 1'b1;
      end else if (state_r == ACS_ST_GAIN && last_period) begin
        bg_gain_next_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // front-end steering and data-ready

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      front <= '{input_sel: ACS_IN_ANALOG, offset_cal: 1'b0, gain_cal: 1'b0};
    end else if (ce) begin
      unique case (state_r)
        ACS_ST_OFFSET: begin
          front.input_sel <= shorted_r ? ACS_IN_SHORTED : ACS_IN_ANALOG;
          front.offset_cal <= 1'b1;
          front.gain_cal <= 1'b0;
        end
        ACS_ST_GAIN: begin
          // system full-scale uses the live input, the others the reference
          front.input_sel <= (op_mode_field_r == ACS_MD_SYS_FS) ?
                             ACS_IN_ANALOG : ACS_IN_REFERENCE;
          front.offset_cal <= 1'b0;
          front.gain_cal <= 1'b1;
        end
        default: begin
          front.input_sel <= ACS_IN_ANALOG;
          front.offset_cal <= 1'b0;
          front.gain_cal <= 1'b0;
        end
      endcase
    end
  end

  // data-ready moves only at a boundary: low in normal conversion and on the boundary
  // that ends a fill or settle phase, so background shows a valid period after each fill
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_valid_n <= 1'b1;
    end else if (ce && tick) begin
      if (state_r == ACS_ST_NORMAL) begin
        result_valid_n <= (op_mode_field_r != ACS_MD_NORMAL);
      end else begin
        result_valid_n <= ~cal_done_ev;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky, cleared by reading, set wins over the clear

  assign cal_done_ev = tick & ((state_r == ACS_ST_FILL) | (state_r == ACS_ST_SETTLE)) &
                       last_period;
  assign valid_ev = tick & (state_r == ACS_ST_NORMAL) & (op_mode_field_r == ACS_MD_NORMAL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
    end else if (ce) begin
      irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | {valid_ev, cal_done_ev};
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

endmodule

// *** testbench/acs_cal_sequencer_sva.sv ***
// checker: port-level timing properties of the calibration sequencer
`timescale 1ns/10ps
module acs_cal_sequencer_sva
  import acs_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire acs_front_s front,
  input wire logic result_valid_n,
  input wire logic conv_tick
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [3:0] off_cnt_r;
  logic [3:0] gain_cnt_r;
  // phases counted in ticks, so a wrong count shows whatever the period
  always_ff @(posedge aclk) begin
    if (!aresetn || !front.offset_cal) begin
      off_cnt_r <= 4'h0;
    end else if (conv_tick && ce) begin
      off_cnt_r <= off_cnt_r + 4'h1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !front.gain_cal) begin
      gain_cnt_r <= 4'h0;
    end else if (conv_tick && ce) begin
      gain_cnt_r <= gain_cnt_r + 4'h1;
    end
  end
  a_valid_on_tick: assert property ($changed(result_valid_n) |-> $past(conv_tick))
    else $error("result_valid_n moved off a boundary");
  a_offset_length: assert property (
    $fell(front.offset_cal) |-> off_cnt_r inside {4'h3, 4'h4})
    else $error("offset phase length wrong");
  a_gain_length: assert property (
    $fell(front.gain_cal) |-> gain_cnt_r inside {4'h3, 4'h4})
    else $error("gain phase length wrong");
  a_short_is_offset: assert property (
    front.input_sel == ACS_IN_SHORTED |-> front.offset_cal && !front.gain_cal)
    else $error("shorted input outside offset phase");
  a_ref_is_gain: assert property (
    front.input_sel == ACS_IN_REFERENCE |-> front.gain_cal && !front.offset_cal)
    else $error("reference input outside gain phase");
  a_tick_single: assert property (conv_tick && ce |=> !conv_tick)
    else $error("tick wider than one cycle");
  a_freeze_hold: assert property (!ce |=> $stable(front) && $stable(result_valid_n))
    else $error("outputs moved with enable low");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_error_zero: assert property (s_axi_rvalid && s_axi_rresp == ACS_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind acs_cal_sequencer acs_cal_sequencer_sva acs_cal_sequencer_sva_inst (
  .aclk, .aresetn, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .front, .result_valid_n, .conv_tick
);

// *** testbench/acs_modulator_model.sv ***
// modulator stand-in: answers each calibration phase with a fixed result word
`timescale 1ns/10ps
module acs_modulator_model
  import acs_pkg::*;
#(
  parameter logic [23:0] OFF_RES = 24'hA50F3C,
  parameter logic [23:0] GAIN_RES = 24'h5AC3F0,
  parameter int LAT = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire acs_front_s front,
  output acs_result_s cal_result
);
  int off_age;
  int gain_age;
  // the word means nothing without its done pulse, so it churns in between
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      off_age <= 0;
      gain_age <= 0;
      cal_result <= '0;
    end else begin
      off_age <= front.offset_cal ? off_age + 1 : 0;
      gain_age <= front.gain_cal ? gain_age + 1 : 0;
      cal_result.offset_done <= front.offset_cal && off_age == LAT;
      cal_result.gain_done <= front.gain_cal && gain_age == LAT;
      if (front.offset_cal && off_age == LAT) begin
        cal_result.result <= OFF_RES;
      end else if (front.gain_cal && gain_age == LAT) begin
        cal_result.result <= GAIN_RES;
      end else begin
        cal_result.result <= ~cal_result.result;
      end
    end
  end
endmodule

// *** testbench/acs_cal_sequencer_test.sv ***
// testbench: registers, every calibration mode and the interrupt of the sequencer
`timescale 1ns/10ps
module acs_cal_sequencer_test
  import acs_pkg::*;
;
  localparam logic [23:0] OFF_RES = 24'hA50F3C;
  localparam logic [23:0] GAIN_RES = 24'h5AC3F0;
  localparam int LIMIT = 20000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic result_valid_n, conv_tick, irq;
  acs_result_s cal_result;
  acs_front_s front;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  acs_cal_sequencer acs_cal_sequencer_inst (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cal_result, .front, .result_valid_n, .conv_tick, .irq
  );
  acs_modulator_model #(.OFF_RES(OFF_RES), .GAIN_RES(GAIN_RES), .LAT(2))
    acs_modulator_model_inst (.aclk, .aresetn, .front, .cal_result);
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 200);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 200) failures++;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 200);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 200) failures++;
    @(posedge aclk);
  endtask
  task automatic tick_wait;
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (conv_tick !== 1'b1 && n < 400);
    if (n >= 400) failures++;
  endtask
  // e: offset, gain, ready-high, shorted and reference periods
  task automatic run_cal(input logic [2:0] md, input logic sl, input int e[5]);
    int c[5];
    int p;
    logic [31:0] d;
    logic [1:0] r;
    c = '{default: 0};
    p = 0;
    tick_wait();
    wr(ACS_CTRL_OFF, {27'h0, sl, 1'b0, md}, r);
    do begin
      tick_wait();
      @(posedge aclk);
      p++;
      if (front.offset_cal === 1'b1) c[0]++;
      if (front.gain_cal === 1'b1) c[1]++;
      if (result_valid_n === 1'b1) c[2]++;
      if (front.input_sel === ACS_IN_SHORTED) c[3]++;
      if (front.input_sel === ACS_IN_REFERENCE) c[4]++;
    end while (result_valid_n !== 1'b0 && p < 24);
    for (int i = 0; i < 5; i++) chk("phase periods", 32'(e[i]), 32'(c[i]));
    rd(ACS_CTRL_OFF, d, r);
    chk("mode after", 32'h0, {29'h0, d[2:0]});
    chk("irq raised", 32'h1, {31'h0, irq});
    rd(ACS_IRQ_STAT_OFF, d, r);
    chk("done flag", 32'h1, {31'h0, d[ACS_IRQ_DONE]});
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("calibration mode %0d done", md);
  endtask
  task automatic t_setup;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    chk("valid_n reset", 32'h1, {31'h0, result_valid_n});
    rd(ACS_PERIOD_OFF, d, r);
    chk("period reset", ACS_PERIOD_RST, d);
    rd(ACS_OFFCAL_OFF, d, r);
    chk("offcal reset", {8'h0, ACS_CAL_RST}, d);
    rd(ACS_CTRL_OFF, d, r);
    chk("ctrl reset", 32'h0, d);
    ce <= 1'b0;
    n = 0;
    repeat (300) begin
      @(posedge aclk);
      if (conv_tick === 1'b1) n++;
    end
    ce <= 1'b1;
    chk("ticks frozen", 32'h0, 32'(n));
    wr(ACS_PERIOD_OFF, 32'h8, r);
    chk("write resp", 32'(ACS_RESP_OKAY), 32'(r));
    rd(8'h1C, d, r);
    chk("unmapped read resp", 32'(ACS_RESP_SLVERR), 32'(r));
    chk("unmapped read data", 32'h0, d);
    wr(8'h1C, 32'hFFFFFFFF, r);
    chk("unmapped write resp", 32'(ACS_RESP_SLVERR), 32'(r));
    wr(ACS_IRQ_MASK_OFF, 32'h1, r);
    $display("setup done");
  endtask
  task automatic t_results;
    logic [31:0] d;
    logic [1:0] r;
    rd(ACS_OFFCAL_OFF, d, r);
    chk("offcal result", {8'h0, OFF_RES}, {8'h0, d[23:0]});
    rd(ACS_FSCAL_OFF, d, r);
    chk("fscal result", {8'h0, GAIN_RES}, {8'h0, d[23:0]});
    wr(ACS_OFFCAL_OFF, 32'h00123456, r);
    rd(ACS_OFFCAL_OFF, d, r);
    chk("offcal override", 32'h00123456, d);
    $display("result registers done");
  endtask
  task automatic t_background;
    logic [31:0] d;
    logic [1:0] r;
    logic prev;
    int n;
    int nv;
    n = 0;
    nv = 0;
    prev = 1'b0;
    wr(ACS_IRQ_MASK_OFF, 32'h0, r);
    tick_wait();
    wr(ACS_CTRL_OFF, {29'h0, ACS_MD_BACKGND}, r);
    repeat (30) begin
      tick_wait();
      @(posedge aclk);
      if (front.offset_cal === 1'b1 && !prev) n++;
      if (result_valid_n === 1'b0) nv++;
      prev = front.offset_cal;
    end
    chk("offset restarts", 32'h1, 32'(n >= 2));
    chk("valid in background", 32'h1, 32'(nv >= 2));
    rd(ACS_CTRL_OFF, d, r);
    chk("mode kept", 32'h5, {29'h0, d[2:0]});
    chk("irq masked", 32'h0, {31'h0, irq});
    rd(ACS_IRQ_STAT_OFF, d, r);
    chk("masked done flag", 32'h1, {31'h0, d[ACS_IRQ_DONE]});
    wr(ACS_CTRL_OFF, 32'h0, r);
    $display("background done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_setup();
    run_cal(ACS_MD_SELF, 1'b1, '{4, 3, 10, 4, 3});
    t_results();
    run_cal(ACS_MD_SYS_OFF, 1'b0, '{3, 0, 4, 0, 0});
    run_cal(ACS_MD_SYS_FS, 1'b1, '{0, 4, 5, 0, 0});
    run_cal(ACS_MD_PSEUDO, 1'b0, '{3, 3, 9, 0, 3});
    t_background();
    complete_run();
  end
endmodule
